// >>> pkg/tbp_pkg.sv
// Package for the timer based ten bit modulator: register map, field layout,
// reset values and the bus and timer carrier structs.
// Assumes one 10 MHz system clock shared by the bus, the timers and the modulator.
package tbp_pkg;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // Register indices on the plain register port
   localparam logic [ADDR_W-1:0] ADDR_CONTROL    = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_DUTY_UPPER = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_DUTY_LOWER = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_TB_SELECT  = 4'h3;

   // Control register fields
   localparam int unsigned CTL_ENABLE_BIT = 7;
   localparam int unsigned CTL_OUT_BIT    = 5;
   localparam int unsigned CTL_INVERT_BIT = 4;
   // Lower duty bits sit in the top two bits of their register
   localparam int unsigned DUTY_LOW_MSB   = 7;
   localparam int unsigned DUTY_LOW_LSB   = 6;

   localparam int unsigned NUM_TIMERS = 3;
   localparam int unsigned SEL_W      = 2;
   localparam logic [SEL_W-1:0] SEL_FIRST_TIMER = 2'h1;
   localparam logic [SEL_W-1:0] SEL_RESERVED    = 2'h0;
   localparam logic [SEL_W-1:0] SEL_RESET       = SEL_FIRST_TIMER;

   localparam logic [DATA_W-1:0] DATA_ZERO    = 8'h00;
   localparam logic [9:0]        DUTY_RESET   = 10'h000;
   localparam logic [1:0]        SUB_ZERO     = 2'h0;
   localparam logic [1:0]        SUB_ONE      = 2'h1;
   localparam logic [9:0]        TB_STEP      = 10'h001;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } tbp_bus_req_t;

   // One period timer as seen by the modulator
   typedef struct packed {
      logic       tick;    // Prescaled instruction-clock tick (advances count)
      logic       fosc_en; // Prescaled system-clock enable for the sub bits
      logic [7:0] count;
      logic [7:0] period;
   } tbp_timer_t;

   typedef tbp_timer_t [NUM_TIMERS-1:0] tbp_timer_set_t;

endpackage

// >>> logic/tbp_modulator.sv
// Ten bit pulse-width modulator with shadowed duty registers and selectable period timer.
// Assumes period timers run on this clock and present count, period and prescaled enables.
`timescale 1ns/1ps

// Notes on behaviour
// - Duty value has ten bits of resolution
// - Time-base select picks timer, first by default
// - Shared period, own independent duty value
// - Timer postscaler plays no part here
// - Output goes active when count clears, unless duty is zero
// - Output inactive when time base equals duty
// - Duty at or above period never clears
// - Shadow duty copied only at period match
// - Invert bit flips the output polarity
// - Period is (value+1) times four times prescale
// - Match then increment: clear, set, latch duty
// - Duty registers writable at any time
// - Time base is count plus two sub bits
// - Prescale one uses raw clock for sub bits
// - Resolution follows period, ten bits at 255
// - Oversized pulse leaves pin level unchanged
// - Sleep freezes time base and level; bus writes still apply
// - Enable bit switches modulator on and off
// - Read-only bit returns current output level
// - Reset restores registers, pin becomes input
module tbp_modulator (
   input  wire logic                   MCLK_IN,
   input  wire logic                   RESETN_IN,
   input  wire logic                   SLEEP_IN,
   input  wire tbp_pkg::tbp_timer_set_t TIMERS_IN,
   input  wire tbp_pkg::tbp_bus_req_t  BUS_IN,
   output logic [tbp_pkg::DATA_W-1:0]  RDATA_OUT,
   output logic                        PWM_OUT,
   output logic                        PWM_PIN_OE_OUT
);
   import tbp_pkg::*;

   typedef struct packed {
      logic              enable;
      logic              invert;
      logic [SEL_W-1:0]  select;
      logic [7:0]        duty_upper;
      logic [1:0]        duty_lower;
      logic [9:0]        duty_work;
      logic [1:0]        sub;
      logic              level;
      logic [DATA_W-1:0] rdata;
   } tbp_state_t;

   tbp_state_t st;
   tbp_state_t next_st;

   tbp_timer_t tmr;
   logic [9:0] time_base;
   logic [9:0] next_time_base;
   logic       match;
   logic       wrap;
   logic       full_on;
   logic       pin_level;

   // Reserved select code falls back to the first timer
   always_comb begin
      if (st.select == SEL_RESERVED) begin
         tmr = TIMERS_IN[0];
      end else begin
         tmr = TIMERS_IN[st.select - SEL_ONE_IDX()];
      end
   end

   function automatic logic [SEL_W-1:0] SEL_ONE_IDX();
      return SEL_FIRST_TIMER;
   endfunction

   always_comb begin
      time_base      = {tmr.count, st.sub};
      // Wraps only in the wrap cycle, which the wrap branch handles
      next_time_base = time_base + TB_STEP;
      // Period ends when count equals period and the tick would wrap it
      match          = (tmr.count == tmr.period);
      wrap           = match && tmr.tick;
      // Upper bits above period means duty at or past 4*(period+1); no carry to lose
      full_on        = (st.duty_work[9:2] > tmr.period);
   end

   always_comb begin
      next_st       = st;
      next_st.rdata = DATA_ZERO;

      // Register writes accepted anywhere in the period
      if (BUS_IN.wr) begin
         unique case (BUS_IN.addr)
            ADDR_CONTROL: begin
               next_st.enable = BUS_IN.wdata[CTL_ENABLE_BIT];
               next_st.invert = BUS_IN.wdata[CTL_INVERT_BIT];
            end
            ADDR_DUTY_UPPER: next_st.duty_upper = BUS_IN.wdata;
            ADDR_DUTY_LOWER: next_st.duty_lower = BUS_IN.wdata[DUTY_LOW_MSB:DUTY_LOW_LSB];
            ADDR_TB_SELECT:  next_st.select     = BUS_IN.wdata[SEL_W-1:0];
            default: ;
         endcase
      end

      if (BUS_IN.rd) begin
         unique case (BUS_IN.addr)
            ADDR_CONTROL: begin
               next_st.rdata[CTL_ENABLE_BIT] = st.enable;
               next_st.rdata[CTL_OUT_BIT]    = pin_level;
               next_st.rdata[CTL_INVERT_BIT] = st.invert;
            end
            ADDR_DUTY_UPPER: next_st.rdata = st.duty_upper;
            ADDR_DUTY_LOWER: next_st.rdata[DUTY_LOW_MSB:DUTY_LOW_LSB] = st.duty_lower;
            ADDR_TB_SELECT:  next_st.rdata[SEL_W-1:0] = st.select;
            default: next_st.rdata = DATA_ZERO;
         endcase
      end

      // Sleep freezes the time base and the output; bus stays usable
      if (!SLEEP_IN && st.enable) begin
         if (wrap) begin
            next_st.sub       = SUB_ZERO;
            next_st.duty_work = {st.duty_upper, st.duty_lower};
            // Zero duty keeps the output inactive for the whole period
            next_st.level     = ({st.duty_upper, st.duty_lower} != DUTY_RESET);
         end else begin
            if (tmr.fosc_en) begin
               next_st.sub = st.sub + SUB_ONE;
               // Compare on every advancing cycle, full ten bits
               // Next time base, so the registered clear lands as the base reaches duty
               if ((next_time_base == st.duty_work) && !full_on) begin
                  next_st.level = 1'b0;
               end
            end
         end
      end else if (!SLEEP_IN) begin
         // Disable waits for wake-up so sleep never moves the pin
         next_st.level = 1'b0;
         next_st.sub   = SUB_ZERO;
      end
   end

   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         st            <= '0;
         st.select     <= SEL_RESET;
         st.duty_work  <= DUTY_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign pin_level      = st.level ^ st.invert;
   assign PWM_OUT        = pin_level;
   // Driver enable follows the module enable; pin direction lives in the port
   assign PWM_PIN_OE_OUT = st.enable;
   assign RDATA_OUT      = st.rdata;

endmodule

// >>> verif/tbp_timer_model.sv
// Model of the three period timers seen by the modulator.
// Assumes prescale 1:1, count advancing every fourth system clock.
`timescale 1ns/1ps
module tbp_timer_model
   import tbp_pkg::*;
(
   input  wire logic           clk_in,
   input  wire logic           rstn_in,
   input  wire logic           hold_in,
   input  wire logic [23:0]    per_in,
   output tbp_timer_set_t      tmr_out
);
   logic [1:0] ph;
   logic [7:0] cnt [3];
   // Frozen while asleep, count resumes from where it stood
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ph <= 2'h0;
         cnt <= '{default: 8'h00};
      end else if (!hold_in) begin
         ph <= ph + 2'h1;
         for (int i = 0; i < 3; i++) begin
            if (ph == 2'h3) cnt[i] <= (cnt[i] == per_in[i*8+:8]) ? 8'h00 : cnt[i] + 8'h01;
         end
      end
   end
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         tmr_out[i] = {(ph == 2'h3) && !hold_in, !hold_in, cnt[i], per_in[i*8+:8]};
      end
   end
endmodule

// >>> verif/tbp_modulator_assertions.sv
// Checker on the modulator ports.
// Assumes bus strobes are single-cycle pulses.
`timescale 1ns/1ps
module tbp_mod_chk
   import tbp_pkg::*;
(
   input wire logic              MCLK_IN,
   input wire logic              RESETN_IN,
   input wire logic              SLEEP_IN,
   input wire tbp_timer_set_t    TIMERS_IN,
   input wire tbp_bus_req_t      BUS_IN,
   input wire logic [DATA_W-1:0] RDATA_OUT,
   input wire logic              PWM_OUT,
   input wire logic              PWM_PIN_OE_OUT
);
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RESETN_IN);
   property p_freeze; SLEEP_IN && !BUS_IN.wr |=> $stable(PWM_OUT); endproperty
   a_freeze: assert property (p_freeze) else $error("output moved in sleep");
   property p_en_wr; BUS_IN.wr && BUS_IN.addr == ADDR_CONTROL |=> PWM_PIN_OE_OUT == $past(BUS_IN.wdata[7]); endproperty
   a_en_wr: assert property (p_en_wr) else $error("enable not taken");
   property p_off; !PWM_PIN_OE_OUT && $past(!PWM_PIN_OE_OUT) && !BUS_IN.wr |=> $stable(PWM_OUT); endproperty
   a_off: assert property (p_off) else $error("disabled output moved");
   property p_ctl; BUS_IN.rd && BUS_IN.addr == ADDR_CONTROL |=> RDATA_OUT[7] == PWM_PIN_OE_OUT && RDATA_OUT[6] == 1'b0
      && RDATA_OUT[5] == $past(PWM_OUT) && RDATA_OUT[3:0] == 4'h0; endproperty
   a_ctl: assert property (p_ctl) else $error("control read wrong");
   property p_low; BUS_IN.rd && BUS_IN.addr == ADDR_DUTY_LOWER |=> RDATA_OUT[5:0] == 6'h00; endproperty
   a_low: assert property (p_low) else $error("lower duty spare bits set");
   property p_sel; BUS_IN.rd && BUS_IN.addr == ADDR_TB_SELECT |=> RDATA_OUT[7:2] == 6'h00; endproperty
   a_sel: assert property (p_sel) else $error("select spare bits set");
   property p_unmap; BUS_IN.rd && BUS_IN.addr > ADDR_TB_SELECT |=> RDATA_OUT == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_idle; !BUS_IN.rd |=> RDATA_OUT == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data without strobe");
   property p_cause; $changed(PWM_OUT) && $past(PWM_PIN_OE_OUT && !BUS_IN.wr) |-> $past(!SLEEP_IN); endproperty
   a_cause: assert property (p_cause) else $error("edge without time base");
endmodule
bind tbp_modulator tbp_mod_chk tbp_mod_chk_i (.MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .SLEEP_IN(SLEEP_IN),
   .TIMERS_IN(TIMERS_IN), .BUS_IN(BUS_IN), .RDATA_OUT(RDATA_OUT), .PWM_OUT(PWM_OUT), .PWM_PIN_OE_OUT(PWM_PIN_OE_OUT));

// >>> verif/test_tbp_modulator.sv
// Bench: register tasks, duty, polarity, timer select and sleep sweeps.
// Assumes timers at prescale 1:1 with periods of 16, 8 and 32 cycles.
`timescale 1ns/1ps
module test_tbp_modulator;
   import tbp_pkg::*;
   logic           clk = 1'b0;
   logic           rstn = 1'b0;
   logic           slp = 1'b0;
   tbp_bus_req_t   bus = '0;
   tbp_timer_set_t tmr;
   logic [7:0]     rdat;
   logic           pwm;
   logic           oe;
   int             err_total = 0;
   int             samples_checked = 0;
   int             cyc = 0;
   int             hi, len, e;
   logic [12:0]    tab [10] = '{13'h0806, 13'h0800, 13'h0810, 13'h0bff, 13'h0c06, 13'h1003, 13'h1008, 13'h181f,
                                13'h0005, 13'h0806};
   tbp_modulator tbp_modulator_i (.MCLK_IN(clk), .RESETN_IN(rstn), .SLEEP_IN(slp), .TIMERS_IN(tmr), .BUS_IN(bus),
      .RDATA_OUT(rdat), .PWM_OUT(pwm), .PWM_PIN_OE_OUT(oe));
   tbp_timer_model tbp_timer_model_i (.clk_in(clk), .rstn_in(rstn), .hold_in(slp), .per_in(24'h070103), .tmr_out(tmr));
   initial forever #50 clk = ~clk;
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic note(input logic ok);
      samples_checked++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED at %0t: value differs", $time);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] x);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      bus <= '0;
      #1 note(rdat === x);
      @(posedge clk);
   endtask
   // Window of 32 holds whole periods of every timer, so phase does not matter
   task automatic cnt_chk(input int x);
      hi = 0;
      // Sample after the launching edge has settled
      repeat (32) begin
         @(posedge clk);
         #1 hi += (pwm === 1'b1);
      end
      @(posedge clk);
      note(hi == x);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd_chk(ADDR_CONTROL, 8'h00);
      note(oe === 1'b0);
      rd_chk(ADDR_TB_SELECT, 8'h01);
      rd_chk(4'hf, 8'h00);
      foreach (tab[i]) begin
         wr(ADDR_TB_SELECT, {6'h00, tab[i][12:11]});
         wr(ADDR_DUTY_UPPER, tab[i][9:2]);
         wr(ADDR_DUTY_LOWER, {tab[i][1:0], 6'h00});
         wr(ADDR_CONTROL, {3'b100, tab[i][10], 4'h0});
         note(oe === 1'b1);
         rd_chk(ADDR_DUTY_LOWER, {tab[i][1:0], 6'h00});
         len = (tab[i][12:11] == 2'h2) ? 8 : (tab[i][12:11] == 2'h3) ? 32 : 16;
         e = (32 / len) * ((tab[i][9:0] < len) ? int'(tab[i][9:0]) : len);
         if (tab[i][10]) e = 32 - e;
         repeat (40) @(posedge clk);
         cnt_chk(e);
         if (e % 32 == 0) rd_chk(ADDR_CONTROL, {2'b10, e == 32, tab[i][10], 4'h0});
      end
      slp <= 1'b1;
      repeat (25) @(posedge clk);
      slp <= 1'b0;
      cnt_chk(12);
      wr(ADDR_CONTROL, 8'h00);
      note(oe === 1'b0);
      cnt_chk(0);
      conclude();
   end
endmodule
